//--- core/status_cfg.svh
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

`define SUM_ACTIVITY_POS 7
`define SUM_SERVICE_POS 6
`define SUM_STDEVT_POS 5
`define SUM_MSGWAIT_POS 4
`define SUM_DOUBTFUL_POS 3
`define SUM_ERRWAIT_POS 2
`define EVT_POWERUP_POS 7
`define EVT_PARSE_POS 5
`define EVT_RUN_POS 4
`define EVT_DEVICE_POS 3
`define EVT_QUERY_POS 2
`define EVT_DONE_POS 0
`define EVT_USED_MASK 8'hbd
`define ERRQ_DEPTH 32
`define ERRQ_OVERFLOW_CODE 16'h015e
`define SELFTEST_PASS_CODE 8'h00
`define MASK_RESET 8'h00

`endif

//--- core/status_pkg.sv
package status_pkg;
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_REMOTE,
        CMD_LOCAL,
        CMD_LOCKOUT,
        CMD_WAIT,
        CMD_OPC,
        CMD_TRIGGER,
        CMD_TRIG_IMM,
        CMD_SELFTEST,
        CMD_POWERON_DEFAULT,
        CMD_POWERON_RESTORE,
        CMD_READ_EVENTS,
        CMD_CLEAR
    } cmd_t;

    typedef enum logic [1:0] {
        PANEL_LOCAL,
        PANEL_REMOTE,
        PANEL_LOCKED
    } panel_t;
endpackage

//--- core/error_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_cfg.svh"

module error_queue #(
    parameter int DEPTH = `ERRQ_DEPTH,
    parameter int WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_code,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_head,
    output logic o_not_empty
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
        $error("error queue depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_r;
    logic [AW-1:0] wr_r;
    logic [AW:0] count_r;
    logic do_pop;
    logic full;

    assign full = (count_r == (AW+1)'(DEPTH));
    assign do_pop = i_pop && (count_r != '0);
    assign o_head = mem[rd_r];
    assign o_not_empty = (count_r != '0);

    // when full, the newest slot becomes the overflow marker
    always_ff @(posedge i_clock) begin
        if (i_push && (!full || do_pop)) begin
            mem[wr_r] <= i_code;
        end else if (i_push && full) begin
            mem[wr_r - AW'(1)] <= WIDTH'(`ERRQ_OVERFLOW_CODE);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst || i_clear) begin
            rd_r <= '0;
            wr_r <= '0;
            count_r <= '0;
        end else begin
            if (i_push && (!full || do_pop)) begin
                wr_r <= wr_r + AW'(1);
            end
            if (do_pop) begin
                rd_r <= rd_r + AW'(1);
            end
            if (i_push && !full && !do_pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (do_pop && !i_push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule

`default_nettype wire

//--- core/status_event_reporting.sv
// Notes on behaviour
// - summary bit 7 set when an enabled activity-group event occurred.
// - summary bit 6 is the service request flag seen by serial poll.
// - summary bit 5 set when any enabled standard event bit is present.
// - summary bit 4 high while a response waits in output queue.
// - summary bit 3 set when an enabled doubtful-group event occurred.
// - summary bit 2 high while the error queue holds an entry.
// - events reach the summary only through a set enable bit.
// - event bit 7 set after power on and after every soft reset.
// - event bit 5 set on a command parse error.
// - event bit 4 set on an execution error.
// - event bit 3 set on a device-dependent error.
// - event bit 2 set on empty-queue read or lost response.
// - event bit 0 set when pending work ends after completion request.
// - lockout disables front panel only in remote mode.
// - remote command enters remote mode; no arguments.
// - power-on choice keeps default or restores last settings.
// - after wait, hold further commands until pending work finishes.
// - self-test returns zero when clean, else fault code.
// - either trigger command raises a trigger pulse at once.
// - new message discards the output queue.
// - error queue holds 32; when full last entry becomes code 350.
// - local command returns to front panel, clearing lockout.
`timescale 1ns/1ps
`default_nettype none
`include "status_cfg.svh"

module status_event_reporting #(
    parameter int ERR_DEPTH = `ERRQ_DEPTH,
    parameter int ERR_WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [3:0] i_cmd,
    input wire logic i_msg_start,
    input wire logic i_resp_push,
    input wire logic i_resp_pop,
    input wire logic i_resp_lost,
    input wire logic i_parse_error,
    input wire logic i_run_error,
    input wire logic i_device_error,
    input wire logic i_error_push,
    input wire logic [ERR_WIDTH-1:0] i_error_code,
    input wire logic i_error_pop,
    input wire logic i_activity_event,
    input wire logic i_doubtful_event,
    input wire logic i_pending_busy,
    input wire logic [7:0] i_selftest_fault,
    input wire logic i_event_mask_we,
    input wire logic [7:0] i_event_mask,
    input wire logic i_service_mask_we,
    input wire logic [7:0] i_service_mask,
    input wire logic i_activity_mask_we,
    input wire logic i_activity_mask,
    input wire logic i_doubtful_mask_we,
    input wire logic i_doubtful_mask,
    output logic [7:0] o_status_summary_byte,
    output logic [7:0] o_standard_event_flags,
    output logic o_service_request,
    output logic [ERR_WIDTH-1:0] o_error_head,
    output logic o_remote,
    output logic o_panel_locked,
    output logic o_restore_last_settings,
    output logic o_cmd_hold,
    output logic o_trigger,
    output logic [7:0] o_selftest_result,
    output logic o_selftest_done
);
    if (ERR_WIDTH < 9) begin
        $error("error code width too small for overflow code");
    end

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    function automatic logic is_cmd(input logic [3:0] c, input status_pkg::cmd_t k);
        is_cmd = (c == 4'(k));
    endfunction

    logic read_events;
    assign read_events = is_cmd(i_cmd, status_pkg::CMD_READ_EVENTS);

    // ----------------------------------------
    // remote / local / lockout
    // ----------------------------------------
    status_pkg::panel_t panel_r;
    status_pkg::panel_t panel_nxt;

    always_comb begin
        panel_nxt = panel_r;
        if (is_cmd(i_cmd, status_pkg::CMD_REMOTE) && panel_r == status_pkg::PANEL_LOCAL) begin
            panel_nxt = status_pkg::PANEL_REMOTE;
        end else if (is_cmd(i_cmd, status_pkg::CMD_LOCAL)) begin
            panel_nxt = status_pkg::PANEL_LOCAL;
        end else if (is_cmd(i_cmd, status_pkg::CMD_LOCKOUT)
                     && panel_r == status_pkg::PANEL_REMOTE) begin
            panel_nxt = status_pkg::PANEL_LOCKED;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            panel_r <= status_pkg::PANEL_LOCAL;
        end else begin
            panel_r <= panel_nxt;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_remote <= 1'b0;
            o_panel_locked <= 1'b0;
        end else begin
            o_remote <= (panel_nxt != status_pkg::PANEL_LOCAL);
            o_panel_locked <= (panel_nxt == status_pkg::PANEL_LOCKED);
        end
    end

    // ----------------------------------------
    // power-on choice
    // ----------------------------------------
    // kept across soft reset: only the choice commands change it
    logic restore_r;
    // power-up value only; no later reset brings it back to zero
    logic restore_init_r = 1'b0;

    always_ff @(posedge i_clock) begin
        if (i_srst && !restore_init_r) begin
            restore_r <= 1'b0;
            restore_init_r <= 1'b1;
        end else if (is_cmd(i_cmd, status_pkg::CMD_POWERON_RESTORE)) begin
            restore_r <= 1'b1;
        end else if (is_cmd(i_cmd, status_pkg::CMD_POWERON_DEFAULT)) begin
            restore_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst && !restore_init_r) begin
            o_restore_last_settings <= 1'b0;
        end else begin
            o_restore_last_settings <= restore_r;
        end
    end

    // ----------------------------------------
    // wait, completion request, trigger, self-test
    // ----------------------------------------
    logic opc_armed_r;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_cmd_hold <= 1'b0;
        end else begin
            if (is_cmd(i_cmd, status_pkg::CMD_WAIT) && i_pending_busy) begin
                o_cmd_hold <= 1'b1;
            end else if (!i_pending_busy) begin
                o_cmd_hold <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            opc_armed_r <= 1'b0;
        end else if (is_cmd(i_cmd, status_pkg::CMD_OPC)) begin
            opc_armed_r <= 1'b1;
        end else if (opc_armed_r && !i_pending_busy) begin
            opc_armed_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_trigger <= 1'b0;
        end else begin
            o_trigger <= is_cmd(i_cmd, status_pkg::CMD_TRIGGER)
                       || is_cmd(i_cmd, status_pkg::CMD_TRIG_IMM);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_selftest_result <= `SELFTEST_PASS_CODE;
            o_selftest_done <= 1'b0;
        end else begin
            o_selftest_done <= is_cmd(i_cmd, status_pkg::CMD_SELFTEST);
            if (is_cmd(i_cmd, status_pkg::CMD_SELFTEST)) begin
                o_selftest_result <= i_selftest_fault;
            end
        end
    end

    // ----------------------------------------
    // output queue occupancy
    // ----------------------------------------
    logic [7:0] resp_count_r;
    logic resp_empty_read;
    assign resp_empty_read = i_resp_pop && resp_count_r == 8'h00 && !i_resp_push;

    always_ff @(posedge i_clock) begin
        if (i_srst || i_msg_start) begin
            resp_count_r <= 8'h00;
        end else if (i_resp_push && !(i_resp_pop && resp_count_r != 8'h00)) begin
            if (resp_count_r != 8'hff) begin
                resp_count_r <= resp_count_r + 8'h01;
            end
        end else if (!i_resp_push && i_resp_pop && resp_count_r != 8'h00) begin
            resp_count_r <= resp_count_r - 8'h01;
        end
    end

    // ----------------------------------------
    // standard event flags
    // ----------------------------------------
    logic [7:0] evt_r;
    logic [7:0] evt_set;
    logic pon_pending_r;

    always_comb begin
        evt_set = 8'h00;
        evt_set[`EVT_POWERUP_POS] = pon_pending_r;
        evt_set[`EVT_PARSE_POS] = i_parse_error;
        evt_set[`EVT_RUN_POS] = i_run_error;
        evt_set[`EVT_DEVICE_POS] = i_device_error;
        evt_set[`EVT_QUERY_POS] = resp_empty_read
                                || i_resp_lost
                                || (i_msg_start && resp_count_r != 8'h00);
        evt_set[`EVT_DONE_POS] = opc_armed_r && !i_pending_busy;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            pon_pending_r <= 1'b1;
        end else begin
            pon_pending_r <= 1'b0;
        end
    end

    // set wins over the read-clear
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            evt_r <= 8'h00;
        end else if (read_events || is_cmd(i_cmd, status_pkg::CMD_CLEAR)) begin
            evt_r <= evt_set & `EVT_USED_MASK;
        end else begin
            evt_r <= (evt_r | evt_set) & `EVT_USED_MASK;
        end
    end

    // ----------------------------------------
    // enable masks and group latches
    // ----------------------------------------
    logic [7:0] evt_mask_r;
    logic [7:0] srv_mask_r;
    logic act_mask_r;
    logic dbt_mask_r;
    logic act_seen_r;
    logic dbt_seen_r;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            evt_mask_r <= `MASK_RESET;
            srv_mask_r <= `MASK_RESET;
            act_mask_r <= 1'b0;
            dbt_mask_r <= 1'b0;
        end else begin
            if (i_event_mask_we) begin
                evt_mask_r <= i_event_mask;
            end
            if (i_service_mask_we) begin
                srv_mask_r <= i_service_mask & ~(8'h01 << `SUM_SERVICE_POS);
            end
            if (i_activity_mask_we) begin
                act_mask_r <= i_activity_mask;
            end
            if (i_doubtful_mask_we) begin
                dbt_mask_r <= i_doubtful_mask;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            act_seen_r <= 1'b0;
            dbt_seen_r <= 1'b0;
        end else if (is_cmd(i_cmd, status_pkg::CMD_CLEAR)) begin
            act_seen_r <= i_activity_event & act_mask_r;
            dbt_seen_r <= i_doubtful_event & dbt_mask_r;
        end else begin
            act_seen_r <= act_seen_r | (i_activity_event & act_mask_r);
            dbt_seen_r <= dbt_seen_r | (i_doubtful_event & dbt_mask_r);
        end
    end

    // ----------------------------------------
    // error queue
    // ----------------------------------------
    logic err_not_empty;
    logic [ERR_WIDTH-1:0] err_head;

    error_queue #(
        .DEPTH(ERR_DEPTH),
        .WIDTH(ERR_WIDTH)
    ) u_errq (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clear(is_cmd(i_cmd, status_pkg::CMD_CLEAR)),
        .i_push(i_error_push),
        .i_code(i_error_code),
        .i_pop(i_error_pop),
        .o_head(err_head),
        .o_not_empty(err_not_empty)
    );

    // ----------------------------------------
    // summary byte and service request
    // ----------------------------------------
    // summary is one cycle behind its sources; a registered output trades latency for timing
    logic [7:0] sum_nxt;

    always_comb begin
        sum_nxt = 8'h00;
        sum_nxt[`SUM_ACTIVITY_POS] = act_seen_r;
        sum_nxt[`SUM_STDEVT_POS] = |(evt_r & evt_mask_r);
        sum_nxt[`SUM_MSGWAIT_POS] = (resp_count_r != 8'h00);
        sum_nxt[`SUM_DOUBTFUL_POS] = dbt_seen_r;
        sum_nxt[`SUM_ERRWAIT_POS] = err_not_empty;
        sum_nxt[`SUM_SERVICE_POS] = |(sum_nxt & srv_mask_r);
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_status_summary_byte <= 8'h00;
            o_service_request <= 1'b0;
            o_standard_event_flags <= 8'h00;
            o_error_head <= '0;
        end else begin
            o_error_head <= err_head;
            o_status_summary_byte <= sum_nxt;
            o_service_request <= sum_nxt[`SUM_SERVICE_POS];
            o_standard_event_flags <= evt_r;
        end
    end
endmodule

`default_nettype wire

//--- testbench/bus_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// remote controller model
// ----
module bus_ctrl_model (
    input wire logic i_clock,
    output logic [3:0] o_cmd,
    output logic o_msg_start,
    output logic o_resp_pop
);
    initial begin
        o_cmd = 4'h0;
        o_msg_start = 1'b0;
        o_resp_pop = 1'b0;
    end
    task automatic send(input status_pkg::cmd_t c);
        @(posedge i_clock);
        o_cmd <= c;
        @(posedge i_clock);
        o_cmd <= status_pkg::CMD_NONE;
        #1;
    endtask
    // rd low loses the pending reply on purpose
    task automatic read_then_msg(input logic rd);
        if (rd) begin
            @(posedge i_clock);
            o_resp_pop <= 1'b1;
            @(posedge i_clock);
            o_resp_pop <= 1'b0;
        end
        @(posedge i_clock);
        o_msg_start <= 1'b1;
        @(posedge i_clock);
        o_msg_start <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/status_event_reporting_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module status_event_reporting_sva (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [3:0] i_cmd,
    input wire logic i_parse_error,
    input wire logic i_pending_busy,
    input wire logic [7:0] i_selftest_fault,
    input wire logic [7:0] o_status_summary_byte,
    input wire logic [7:0] o_standard_event_flags,
    input wire logic o_service_request,
    input wire logic o_remote,
    input wire logic o_panel_locked,
    input wire logic o_cmd_hold,
    input wire logic o_trigger,
    input wire logic [7:0] o_selftest_result,
    input wire logic o_selftest_done
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    logic trig_cmd;
    assign trig_cmd = (i_cmd == status_pkg::CMD_TRIGGER) || (i_cmd == status_pkg::CMD_TRIG_IMM);
    a_trigger_pulse: assert property (o_trigger == $past(trig_cmd))
        else $error("trigger pulse wrong");
    a_service_mirror: assert property ((o_status_summary_byte[6] == o_service_request)
        && (!o_service_request || (o_status_summary_byte & 8'hbf) != 8'h00))
        else $error("service flag differs");
    a_lock_needs_remote: assert property (o_panel_locked |-> o_remote)
        else $error("locked while local");
    a_lockout_local: assert property ((i_cmd == status_pkg::CMD_LOCKOUT) && !o_remote
        |=> !o_panel_locked) else $error("lockout took effect in local");
    a_remote_enter: assert property ((i_cmd == status_pkg::CMD_REMOTE) |=> o_remote)
        else $error("remote not entered");
    a_local_exit: assert property ((i_cmd == status_pkg::CMD_LOCAL)
        |=> !o_remote && !o_panel_locked) else $error("local not restored");
    a_selftest_answer: assert property ((i_cmd == status_pkg::CMD_SELFTEST)
        |=> o_selftest_done && (o_selftest_result == $past(i_selftest_fault)))
        else $error("self-test answer wrong");
    a_parse_flag: assert property (i_parse_error && (i_cmd != status_pkg::CMD_CLEAR)
        |-> ##2 o_standard_event_flags[5]) else $error("parse flag missing");
    a_powerup_flag: assert property ($fell(i_srst) |-> ##2 o_standard_event_flags[7])
        else $error("power-up flag missing");
    a_wait_hold: assert property ((i_cmd == status_pkg::CMD_WAIT) && i_pending_busy
        |=> o_cmd_hold) else $error("wait did not hold");
    c_trigger: cover property (o_trigger);
    c_locked: cover property (o_panel_locked);
    c_service: cover property (o_service_request);
endmodule
bind status_event_reporting status_event_reporting_sva u_sva (
    .i_clock(i_clock), .i_srst(i_srst), .i_cmd(i_cmd), .i_parse_error(i_parse_error),
    .i_pending_busy(i_pending_busy), .i_selftest_fault(i_selftest_fault),
    .o_status_summary_byte(o_status_summary_byte),
    .o_standard_event_flags(o_standard_event_flags), .o_service_request(o_service_request),
    .o_remote(o_remote), .o_panel_locked(o_panel_locked), .o_cmd_hold(o_cmd_hold),
    .o_trigger(o_trigger), .o_selftest_result(o_selftest_result),
    .o_selftest_done(o_selftest_done)
);
`default_nettype wire

//--- testbench/status_event_reporting_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module status_event_reporting_bench;
    logic i_clock, i_srst, busy, act_m, dbt_m, srq, remote, locked, restore, hold, trig;
    logic msg, pop, st_done;
    logic [8:0] pls;
    logic [3:0] we, cmd;
    logic [15:0] err_code, head;
    logic [7:0] fault, ev_m, sv_m, sum, flags, st_res;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    status_event_reporting dut (
        .i_clock(i_clock), .i_srst(i_srst), .i_cmd(cmd), .i_msg_start(msg),
        .i_resp_push(pls[0]), .i_resp_pop(pop), .i_resp_lost(pls[1]),
        .i_parse_error(pls[2]), .i_run_error(pls[3]), .i_device_error(pls[4]),
        .i_error_push(pls[5]), .i_error_code(err_code), .i_error_pop(pls[6]),
        .i_activity_event(pls[7]), .i_doubtful_event(pls[8]), .i_pending_busy(busy),
        .i_selftest_fault(fault), .i_event_mask_we(we[0]), .i_event_mask(ev_m),
        .i_service_mask_we(we[1]), .i_service_mask(sv_m), .i_activity_mask_we(we[2]),
        .i_activity_mask(act_m), .i_doubtful_mask_we(we[3]), .i_doubtful_mask(dbt_m),
        .o_status_summary_byte(sum), .o_standard_event_flags(flags),
        .o_service_request(srq), .o_error_head(head), .o_remote(remote),
        .o_panel_locked(locked), .o_restore_last_settings(restore), .o_cmd_hold(hold),
        .o_trigger(trig), .o_selftest_result(st_res), .o_selftest_done(st_done)
    );
    bus_ctrl_model ctrl (.i_clock(i_clock), .o_cmd(cmd), .o_msg_start(msg), .o_resp_pop(pop));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge i_clock);
        pls <= m;
        @(posedge i_clock);
        pls <= 9'h000;
    endtask
    task automatic setm(input logic [7:0] e, input logic [7:0] s, input logic a, input logic d);
        @(posedge i_clock);
        we <= 4'hf;
        {ev_m, sv_m, act_m, dbt_m} <= {e, s, a, d};
        @(posedge i_clock);
        we <= 4'h0;
    endtask
    task automatic reset_dut();
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        tick(3);
    endtask
    task automatic t_events();
        chk(flags[7], 1'b1, "power-up flag");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
        setm(8'hbd, 8'h20, 1'b0, 1'b0);
        pulse(9'h01c);
        tick(3);
        chk(flags, 8'h38, "error flags");
        chk(sum, 8'h60, "summary with service");
        chk(srq, 1'b1, "service request");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
        setm(8'hbd, 8'h00, 1'b0, 1'b0);
        pulse(9'h004);
        tick(3);
        chk(sum, 8'h20, "service masked off");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
    endtask
    task automatic t_masks();
        setm(8'h00, 8'h00, 1'b0, 1'b0);
        pulse(9'h190);
        tick(3);
        chk(sum, 8'h00, "events blocked");
        chk(flags, 8'h08, "device flag");
        ctrl.send(status_pkg::CMD_CLEAR);
        setm(8'h08, 8'h80, 1'b1, 1'b1);
        pulse(9'h190);
        tick(3);
        chk(sum, 8'he8, "group summaries");
        ctrl.send(status_pkg::CMD_CLEAR);
        setm(8'h00, 8'h00, 1'b0, 1'b0);
    endtask
    task automatic t_queues();
        pulse(9'h001);
        tick(3);
        chk(sum[4], 1'b1, "message waiting");
        ctrl.read_then_msg(1'b1);
        tick(3);
        chk({sum[4], flags[2]}, 2'b00, "read then message");
        pulse(9'h001);
        ctrl.read_then_msg(1'b0);
        tick(3);
        chk(flags[2], 1'b1, "unread reply lost");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
        ctrl.read_then_msg(1'b1);
        tick(3);
        chk(flags[2], 1'b1, "empty read");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
        pulse(9'h002);
        tick(3);
        chk(flags[2], 1'b1, "lost response");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
        for (int k = 1; k <= 33; k++) begin
            @(posedge i_clock);
            err_code <= 16'(k);
            pulse(9'h020);
        end
        tick(2);
        chk(sum[2], 1'b1, "error waiting");
        for (int k = 1; k <= 32; k++) begin
            chk(head, (k == 32) ? 16'h015e : 16'(k), "error queue head");
            pulse(9'h040);
            tick(1);
        end
        tick(2);
        chk(sum[2], 1'b0, "error queue empty");
    endtask
    task automatic t_modes();
        ctrl.send(status_pkg::CMD_LOCKOUT);
        chk(locked, 1'b0, "lockout in local");
        ctrl.send(status_pkg::CMD_REMOTE);
        chk(remote, 1'b1, "remote");
        ctrl.send(status_pkg::CMD_LOCKOUT);
        chk(locked, 1'b1, "lockout in remote");
        ctrl.send(status_pkg::CMD_LOCAL);
        chk({remote, locked}, 2'b00, "local");
        ctrl.send(status_pkg::CMD_POWERON_RESTORE);
        tick(1);
        chk(restore, 1'b1, "restore choice");
        reset_dut();
        chk(restore, 1'b1, "choice kept");
        ctrl.send(status_pkg::CMD_POWERON_DEFAULT);
        tick(1);
        chk(restore, 1'b0, "default choice");
        ctrl.send(status_pkg::CMD_READ_EVENTS);
    endtask
    task automatic t_misc();
        ctrl.send(status_pkg::CMD_TRIGGER);
        chk(trig, 1'b1, "trigger");
        ctrl.send(status_pkg::CMD_TRIG_IMM);
        chk(trig, 1'b1, "immediate trigger");
        tick(1);
        chk(trig, 1'b0, "trigger pulse end");
        ctrl.send(status_pkg::CMD_SELFTEST);
        chk({st_done, st_res}, 9'h100, "self-test pass");
        @(posedge i_clock);
        fault <= 8'h2a;
        ctrl.send(status_pkg::CMD_SELFTEST);
        chk({st_done, st_res}, 9'h12a, "self-test fault");
        @(posedge i_clock);
        busy <= 1'b1;
        ctrl.send(status_pkg::CMD_WAIT);
        tick(5);
        chk(hold, 1'b1, "wait holds");
        ctrl.send(status_pkg::CMD_OPC);
        tick(4);
        chk(flags[0], 1'b0, "done too early");
        @(posedge i_clock);
        busy <= 1'b0;
        tick(4);
        chk({hold, flags[0]}, 2'b01, "work finished");
    endtask
    initial begin
        {pls, we, err_code, fault, ev_m, sv_m, act_m, dbt_m, busy} = '0;
        i_srst = 1'b1;
        reset_dut();
        t_events();
        t_masks();
        t_queues();
        t_modes();
        t_misc();
        results();
    end
endmodule
`default_nettype wire
